// ==== core/usr_defs.svh ====
`ifndef USR_DEFS_SVH
`define USR_DEFS_SVH
// Contract
// - async receive oversamples at sixteen times bitrate
// - async when clocked-mode clear, port enabled
// - word sets receive flag, irq if enabled
// - ninth enable gives 9-bit words, bit in status
// - low eight bits read from receive buffer
// - clearing continuous enable clears latched errors
// - address detect filters; cleared lets all through
// - synchronous master is half duplex
// - clocked-mode bit selects synchronous pin functions
// - clock source bit makes device drive clock
// - shifter loads from buffer after last bit
// - transfer empties buffer and sets empty flag
// - empty flag ignores software, clears on write
// - shifter empty status readable, no interrupt
// - empty flag drops two cycles after write
// - buffer write starts synchronous master transmit
// - sync receive starts on single or continuous
// - sync receive samples on driven falling edge
// - single takes one word; continuous wins
// - async frame start, 8/9 data, stop, no parity
// - least significant bit shifted first
// - baud clock x16 or x64 by speed select

// register indices
`define USR_ADDR_RCV_CTL 3'h0
`define USR_ADDR_RCV_BUF 3'h1
`define USR_ADDR_TX_CTL 3'h2
`define USR_ADDR_BAUD 3'h3
`define USR_ADDR_TX_BUF 3'h4
`define USR_ADDR_FLAGS 3'h5
`define USR_ADDR_ENABLES 3'h6

// receive_control_status fields
`define USR_RCS_PORT_EN 7
`define USR_RCS_RX9 6
`define USR_RCS_SINGLE 5
`define USR_RCS_CONT 4
`define USR_RCS_ADDR_DET 3

// transmit_control_status fields
`define USR_TXS_CLK_SRC 7
`define USR_TXS_TX9 6
`define USR_TXS_TX_EN 5
`define USR_TXS_SYNC 4
`define USR_TXS_HIGH_SPD 2
`define USR_TXS_TX9_BIT 0

// flag and enable fields
`define USR_FLG_RCV 5
`define USR_FLG_TX 4

// reset values
`define USR_BYTE_RESET 8'h00
`define USR_BIT_RESET 1'h0
`define USR_SHIFTER_EMPTY_RESET 1'h1

// oversampling and data bit counts
`define USR_OVS_MID 4'h7
`define USR_OVS_LAST 4'hF
`define USR_BITS_8 4'h8
`define USR_BITS_9 4'h9
`endif

// ==== core/usr_pkg.sv ====
package usr_pkg;
    // one register byte
    typedef logic [7:0] usr_byte_t;
    // async receiver phases
    typedef enum logic [1:0] {
        usr_ar_idle = 2'b00,
        usr_ar_start = 2'b01,
        usr_ar_data = 2'b10,
        usr_ar_stop = 2'b11
    } usr_arx_e;
    // synchronous master phases
    typedef enum logic [1:0] {
        usr_sm_idle = 2'b00,
        usr_sm_tx = 2'b01,
        usr_sm_rx = 2'b10
    } usr_sync_e;
endpackage

// ==== core/usr_sync3.sv ====
`timescale 1ns/1ps
module usr_sync3 #(
    parameter logic IDLE_LEVEL = 1'h1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic pin_in,
    output logic level
);
    logic ff1_q; // metastable stage, read only by ff2
    logic ff2_q;
    logic ff3_q;
    logic level_q; // filtered level

    // three stages; level moves only when the last two agree
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ff1_q <= IDLE_LEVEL;
            ff2_q <= IDLE_LEVEL;
            ff3_q <= IDLE_LEVEL;
            level_q <= IDLE_LEVEL;
        end else begin
            ff1_q <= pin_in;
            ff2_q <= ff1_q;
            ff3_q <= ff2_q;
            if (ff2_q == ff3_q) begin
                level_q <= ff3_q;
            end
        end
    end

    assign level = level_q;
endmodule

// ==== core/usr_baud.sv ====
`timescale 1ns/1ps
module usr_baud (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic slow,
    input wire logic [7:0] divisor,
    output logic tick
);
    logic [7:0] cnt_q; // divisor counter
    logic [1:0] pre_q; // extra divide by four
    logic tick_q;
    wire wrap = (cnt_q == divisor);
    wire pre_last = !slow || (pre_q == 2'h3);

    // tick every divisor+1 cycles, or four times that when slow
    always_ff @(posedge sys_clk) begin
        if (rst || !run) begin
            cnt_q <= 8'h00;
            pre_q <= 2'h0;
            tick_q <= 1'h0;
        end else begin
            tick_q <= wrap && pre_last;
            cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
            if (wrap) begin
                pre_q <= pre_last ? 2'h0 : pre_q + 2'h1;
            end
        end
    end

    assign tick = tick_q;
endmodule

// ==== core/usr_top.sv ====
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "usr_defs.svh"
module usr_top (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] reg_addr,
    input wire usr_pkg::usr_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output usr_pkg::usr_byte_t reg_rdata,
    input wire logic serial_data_pin_i,
    output logic serial_data_pin_o,
    output logic serial_data_pin_oe_n,
    output logic shift_clock_pin_o,
    output logic shift_clock_pin_oe_n,
    output logic receive_irq_req,
    output logic transmit_irq_req
);
    import usr_pkg::*;

    // address match, shared by every strobe decode
    function automatic logic hit(input logic [2:0] a, input logic [2:0] o);
        return a == o;
    endfunction

    // place a shifted word: 9-bit sits in [8:0], 8-bit in [8:1]
    function automatic logic [8:0] align(input logic [8:0] s, input logic nine);
        return nine ? s : {1'h0, s[8:1]};
    endfunction

    // receive control fields
    logic port_enable_q;
    logic receive_ninth_enable_q;
    logic single_receive_enable_q;
    logic continuous_receive_enable_q;
    logic address_detect_enable_q;
    logic framing_error_q;
    logic overrun_error_q;
    logic receive_ninth_bit_q;
    // transmit control fields
    logic clock_source_select_q;
    logic transmit_ninth_enable_q;
    logic transmit_enable_q;
    logic sync_mode_q;
    logic high_speed_select_q;
    logic transmit_ninth_bit_q;
    logic shifter_empty_status_q;
    // data and flags
    usr_byte_t baud_divisor_value_q;
    usr_byte_t receive_buffer_q;
    usr_byte_t transmit_buffer_q;
    logic tx_full_q; // buffer holds a word not yet loaded
    logic receive_full_flag_q;
    logic transmit_empty_flag_q;
    logic receive_irq_enable_q;
    logic transmit_irq_enable_q;
    // output stage
    usr_byte_t rdata_q;
    logic data_o_q;
    logic data_oe_n_q;
    logic clk_o_q;
    logic clk_oe_n_q;
    logic rx_irq_q;
    logic tx_irq_q;
    // async receiver
    usr_arx_e ar_state_q;
    logic [3:0] ovs_q; // sixteenth-of-bit counter
    logic [3:0] ar_cnt_q; // data bits taken
    logic [8:0] ar_shift_q;
    logic ar_done_q; // one-cycle word pulse
    logic ar_stop_low_q;
    // synchronous master
    usr_sync_e sm_state_q;
    logic sm_clk_q; // internal shift clock level
    logic [3:0] sm_cnt_q;
    logic [8:0] transmit_shifter_q;
    logic [8:0] sm_rx_q;
    logic sm_done_q; // one-cycle word pulse

    logic tick;
    logic rx_level;

    // strobe decodes
    wire wr_rcs = reg_wr && hit(reg_addr, `USR_ADDR_RCV_CTL);
    wire wr_txs = reg_wr && hit(reg_addr, `USR_ADDR_TX_CTL);
    wire wr_baud = reg_wr && hit(reg_addr, `USR_ADDR_BAUD);
    wire wr_txb = reg_wr && hit(reg_addr, `USR_ADDR_TX_BUF);
    wire wr_ena = reg_wr && hit(reg_addr, `USR_ADDR_ENABLES);
    wire rd_rxb = reg_rd && hit(reg_addr, `USR_ADDR_RCV_BUF);

    // operating modes
    wire async_on = port_enable_q && !sync_mode_q;
    wire master_on = port_enable_q && sync_mode_q && clock_source_select_q;
    wire arx_run = async_on && continuous_receive_enable_q && !overrun_error_q;
    wire [3:0] rx_bits = receive_ninth_enable_q ? `USR_BITS_9 : `USR_BITS_8;
    wire [3:0] tx_bits = transmit_ninth_enable_q ? `USR_BITS_9 : `USR_BITS_8;
    wire rx_req = single_receive_enable_q || continuous_receive_enable_q;
    wire ovs_last = tick && (ovs_q == `USR_OVS_LAST);
    wire ar_stop_hit = arx_run && ovs_last && (ar_state_q == usr_ar_stop);
    wire sm_idle = (sm_state_q == usr_sm_idle);
    // transmit goes first when both could start; halves never overlap
    wire load_tx = master_on && transmit_enable_q && tx_full_q && sm_idle;
    wire start_rx = master_on && rx_req && sm_idle && !load_tx;
    wire sm_fall = tick && sm_clk_q;
    wire sm_last_rx = (sm_state_q == usr_sm_rx) && sm_fall && (sm_cnt_q == rx_bits - 4'h1);
    wire continuous_receive_enable_fall = wr_rcs && !reg_wdata[`USR_RCS_CONT] && continuous_receive_enable_q;

    // word assembly and buffer decision
    wire word_done = ar_done_q || sm_done_q;
    wire [8:0] word = ar_done_q ? align(ar_shift_q, receive_ninth_enable_q)
                                : align(sm_rx_q, receive_ninth_enable_q);
    // address detect only matters for 9-bit async words
    wire addr_drop = ar_done_q && address_detect_enable_q && receive_ninth_enable_q
                     && !word[8];
    wire take = word_done && !addr_drop;
    wire overrun = take && receive_full_flag_q && !rd_rxb;
    wire accept = take && !overrun;

    // read views; unused bit 3 of transmit status reads zero
    wire [7:0] rcs_val = {port_enable_q, receive_ninth_enable_q, single_receive_enable_q,
                          continuous_receive_enable_q, address_detect_enable_q,
                          framing_error_q, overrun_error_q, receive_ninth_bit_q};
    wire [7:0] txs_val = {clock_source_select_q, transmit_ninth_enable_q, transmit_enable_q,
                          sync_mode_q, 1'h0, high_speed_select_q, shifter_empty_status_q,
                          transmit_ninth_bit_q};
    wire [7:0] flg_val = {2'h0, receive_full_flag_q, transmit_empty_flag_q, 4'h0};
    wire [7:0] ena_val = {2'h0, receive_irq_enable_q, transmit_irq_enable_q, 4'h0};
    wire [7:0] rd_mux =
        hit(reg_addr, `USR_ADDR_RCV_CTL) ? rcs_val :
        hit(reg_addr, `USR_ADDR_RCV_BUF) ? receive_buffer_q :
        hit(reg_addr, `USR_ADDR_TX_CTL) ? txs_val :
        hit(reg_addr, `USR_ADDR_BAUD) ? baud_divisor_value_q :
        hit(reg_addr, `USR_ADDR_TX_BUF) ? transmit_buffer_q :
        hit(reg_addr, `USR_ADDR_FLAGS) ? flg_val :
        hit(reg_addr, `USR_ADDR_ENABLES) ? ena_val : 8'h00;

    // baud: async ticks at x16 of bit rate, prescaled by four when not high speed
    usr_baud u_baud (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(async_on || master_on),
        .slow(async_on && !high_speed_select_q),
        .divisor(baud_divisor_value_q),
        .tick(tick)
    );

    // data pin comes from outside the clock domain
    usr_sync3 #(.IDLE_LEVEL(1'h1)) u_rx_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_in(serial_data_pin_i),
        .level(rx_level)
    );

    // receive control register; single enable self-clears after its word
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            port_enable_q <= `USR_BIT_RESET;
            receive_ninth_enable_q <= `USR_BIT_RESET;
            single_receive_enable_q <= `USR_BIT_RESET;
            continuous_receive_enable_q <= `USR_BIT_RESET;
            address_detect_enable_q <= `USR_BIT_RESET;
        end else if (wr_rcs) begin
            port_enable_q <= reg_wdata[`USR_RCS_PORT_EN];
            receive_ninth_enable_q <= reg_wdata[`USR_RCS_RX9];
            single_receive_enable_q <= reg_wdata[`USR_RCS_SINGLE];
            continuous_receive_enable_q <= reg_wdata[`USR_RCS_CONT];
            address_detect_enable_q <= reg_wdata[`USR_RCS_ADDR_DET];
        end else if (sm_last_rx && !continuous_receive_enable_q) begin
            single_receive_enable_q <= 1'h0;
        end
    end

    // transmit control register and divisor
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clock_source_select_q <= `USR_BIT_RESET;
            transmit_ninth_enable_q <= `USR_BIT_RESET;
            transmit_enable_q <= `USR_BIT_RESET;
            sync_mode_q <= `USR_BIT_RESET;
            high_speed_select_q <= `USR_BIT_RESET;
            transmit_ninth_bit_q <= `USR_BIT_RESET;
            baud_divisor_value_q <= `USR_BYTE_RESET;
        end else begin
            if (wr_txs) begin
                clock_source_select_q <= reg_wdata[`USR_TXS_CLK_SRC];
                transmit_ninth_enable_q <= reg_wdata[`USR_TXS_TX9];
                transmit_enable_q <= reg_wdata[`USR_TXS_TX_EN];
                sync_mode_q <= reg_wdata[`USR_TXS_SYNC];
                high_speed_select_q <= reg_wdata[`USR_TXS_HIGH_SPD];
                transmit_ninth_bit_q <= reg_wdata[`USR_TXS_TX9_BIT];
            end
            if (wr_baud) begin
                baud_divisor_value_q <= reg_wdata;
            end
        end
    end

    // interrupt enables
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            receive_irq_enable_q <= `USR_BIT_RESET;
            transmit_irq_enable_q <= `USR_BIT_RESET;
        end else if (wr_ena) begin
            receive_irq_enable_q <= reg_wdata[`USR_FLG_RCV];
            transmit_irq_enable_q <= reg_wdata[`USR_FLG_TX];
        end
    end

    // transmit buffer; a write in the load cycle wins, so no word is lost
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            transmit_buffer_q <= `USR_BYTE_RESET;
            tx_full_q <= 1'h0;
        end else if (wr_txb) begin
            transmit_buffer_q <= reg_wdata;
            tx_full_q <= 1'h1;
        end else if (load_tx) begin
            tx_full_q <= 1'h0;
        end
    end

    // empty flag follows the full bit one cycle late, so it drops two
    // cycles after the write; software has no path to it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            transmit_empty_flag_q <= `USR_BIT_RESET;
        end else begin
            transmit_empty_flag_q <= transmit_enable_q && !tx_full_q;
        end
    end

    // async receiver: start check at mid start bit, then every 16 ticks
    always_ff @(posedge sys_clk) begin
        if (rst || !arx_run) begin
            ar_state_q <= usr_ar_idle;
            ovs_q <= 4'h0;
            ar_cnt_q <= 4'h0;
            ar_shift_q <= 9'h000;
        end else if (tick) begin
            ovs_q <= ovs_q + 4'h1;
            case (ar_state_q)
                usr_ar_idle: begin
                    ovs_q <= 4'h0;
                    if (!rx_level) begin
                        ar_state_q <= usr_ar_start;
                    end
                end
                usr_ar_start: begin
                    // a glitch shorter than half a bit is not a start
                    if (ovs_q == `USR_OVS_MID) begin
                        ovs_q <= 4'h0;
                        ar_cnt_q <= 4'h0;
                        ar_state_q <= rx_level ? usr_ar_idle : usr_ar_data;
                    end
                end
                usr_ar_data: begin
                    if (ovs_q == `USR_OVS_LAST) begin
                        ar_shift_q <= {rx_level, ar_shift_q[8:1]};
                        ar_cnt_q <= ar_cnt_q + 4'h1;
                        if (ar_cnt_q == rx_bits - 4'h1) begin
                            ar_state_q <= usr_ar_stop;
                        end
                    end
                end
                usr_ar_stop: begin
                    if (ovs_q == `USR_OVS_LAST) begin
                        ar_state_q <= usr_ar_idle;
                    end
                end
                default: begin
                    ar_state_q <= usr_ar_idle;
                end
            endcase
        end
    end

    // word pulse and stop level, taken at mid stop bit
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ar_done_q <= 1'h0;
            ar_stop_low_q <= 1'h0;
        end else begin
            ar_done_q <= ar_stop_hit;
            if (ar_stop_hit) begin
                ar_stop_low_q <= !rx_level;
            end
        end
    end

    // synchronous master: each tick flips the clock, falling edge ends a bit
    always_ff @(posedge sys_clk) begin
        if (rst || !master_on) begin
            sm_state_q <= usr_sm_idle;
            sm_clk_q <= 1'h0;
            sm_cnt_q <= 4'h0;
            transmit_shifter_q <= 9'h000;
            sm_rx_q <= 9'h000;
            shifter_empty_status_q <= `USR_SHIFTER_EMPTY_RESET;
        end else begin
            case (sm_state_q)
                usr_sm_idle: begin
                    sm_clk_q <= 1'h0;
                    sm_cnt_q <= 4'h0;
                    if (load_tx) begin
                        transmit_shifter_q <= {transmit_ninth_bit_q, transmit_buffer_q};
                        shifter_empty_status_q <= 1'h0;
                        sm_state_q <= usr_sm_tx;
                    end else if (start_rx) begin
                        sm_state_q <= usr_sm_rx;
                    end
                end
                usr_sm_tx: begin
                    if (tick) begin
                        sm_clk_q <= !sm_clk_q;
                    end
                    if (sm_fall) begin
                        transmit_shifter_q <= {1'h0, transmit_shifter_q[8:1]};
                        sm_cnt_q <= sm_cnt_q + 4'h1;
                        if (sm_cnt_q == tx_bits - 4'h1) begin
                            shifter_empty_status_q <= 1'h1;
                            sm_state_q <= usr_sm_idle;
                        end
                    end
                end
                usr_sm_rx: begin
                    if (!rx_req) begin
                        sm_state_q <= usr_sm_idle; // enable withdrawn mid word
                    end else begin
                        if (tick) begin
                            sm_clk_q <= !sm_clk_q;
                        end
                        if (sm_fall) begin
                            sm_rx_q <= {rx_level, sm_rx_q[8:1]};
                            sm_cnt_q <= sm_cnt_q + 4'h1;
                        end
                        if (sm_last_rx) begin
                            sm_state_q <= usr_sm_idle;
                        end
                    end
                end
                default: begin
                    sm_state_q <= usr_sm_idle;
                end
            endcase
        end
    end

    // sync word pulse follows the last sample by one cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sm_done_q <= 1'h0;
        end else begin
            sm_done_q <= sm_last_rx && master_on && rx_req;
        end
    end

    // receive buffer and its ninth bit travel together
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            receive_buffer_q <= `USR_BYTE_RESET;
            receive_ninth_bit_q <= `USR_BIT_RESET;
        end else if (accept) begin
            receive_buffer_q <= word[7:0];
            receive_ninth_bit_q <= word[8];
        end
    end

    // sticky receive flags; a new event beats a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            receive_full_flag_q <= `USR_BIT_RESET;
            framing_error_q <= `USR_BIT_RESET;
            overrun_error_q <= `USR_BIT_RESET;
        end else begin
            if (accept) begin
                receive_full_flag_q <= 1'h1;
            end else if (rd_rxb) begin
                receive_full_flag_q <= 1'h0;
            end
            if (accept && ar_done_q && ar_stop_low_q) begin
                framing_error_q <= 1'h1;
            end else if (accept || continuous_receive_enable_fall) begin
                framing_error_q <= 1'h0;
            end
            if (overrun) begin
                overrun_error_q <= 1'h1;
            end else if (continuous_receive_enable_fall) begin
                overrun_error_q <= 1'h0;
            end
        end
    end

    // registered outputs; pins lag the internal state by one cycle alike
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
            data_o_q <= 1'h1;
            data_oe_n_q <= 1'h1;
            clk_o_q <= 1'h0;
            clk_oe_n_q <= 1'h1;
            rx_irq_q <= 1'h0;
            tx_irq_q <= 1'h0;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 8'h00;
            data_o_q <= (sm_state_q == usr_sm_tx) ? transmit_shifter_q[0] : 1'h1;
            data_oe_n_q <= !(master_on && sm_state_q == usr_sm_tx);
            clk_o_q <= sm_clk_q;
            clk_oe_n_q <= !master_on;
            rx_irq_q <= receive_full_flag_q && receive_irq_enable_q;
            tx_irq_q <= transmit_empty_flag_q && transmit_irq_enable_q;
        end
    end

    assign reg_rdata = rdata_q;
    assign serial_data_pin_o = data_o_q;
    assign serial_data_pin_oe_n = data_oe_n_q;
    assign shift_clock_pin_o = clk_o_q;
    assign shift_clock_pin_oe_n = clk_oe_n_q;
    assign receive_irq_req = rx_irq_q;
    assign transmit_irq_req = tx_irq_q;
endmodule

// ==== verif/usr_top_properties.sv ====
`timescale 1ns/1ps
module usr_top_properties (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire usr_pkg::usr_byte_t reg_rdata,
    input wire logic serial_data_pin_o,
    input wire logic serial_data_pin_oe_n,
    input wire logic shift_clock_pin_o,
    input wire logic shift_clock_pin_oe_n,
    input wire logic receive_irq_req,
    input wire logic transmit_irq_req
);
    import usr_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // read data stands only in the slot after a strobe
    property p_rd_slot; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_rd_slot: assert property (p_rd_slot) else $error("read data out of slot");
    // undriven data line rests high
    property p_dat_idle; serial_data_pin_oe_n |-> serial_data_pin_o; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data not idle");
    // data is driven only while mastering the clock
    property p_tx_master; !serial_data_pin_oe_n |-> !shift_clock_pin_oe_n; endproperty
    a_tx_master: assert property (p_tx_master) else $error("data driven as non master");
    // clock moves only while it is driven
    property p_clk_master; $changed(shift_clock_pin_o) |-> !$past(shift_clock_pin_oe_n); endproperty
    a_clk_master: assert property (p_clk_master) else $error("clock moved undriven");
    // a bit holds while the clock is high, so the slave sees it settled
    property p_bit_hold;
        !serial_data_pin_oe_n && shift_clock_pin_o |-> $stable(serial_data_pin_o);
    endproperty
    a_bit_hold: assert property (p_bit_hold) else $error("data moved on high clock");
    // empty flag drops only after a register write
    property p_tx_fall; $fell(transmit_irq_req) |-> $past(reg_wr, 2) || $past(reg_wr, 3); endproperty
    a_tx_fall: assert property (p_tx_fall) else $error("empty flag dropped alone");
    // receive request drops only after a read or write
    property p_rx_fall; $fell(receive_irq_req) |-> $past(reg_rd, 2) || $past(reg_wr, 2); endproperty
    a_rx_fall: assert property (p_rx_fall) else $error("receive request dropped alone");
    // pins stay released out of reset
    property p_rst_idle; $fell(rst) |-> serial_data_pin_oe_n && shift_clock_pin_oe_n; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("pins driven after reset");
endmodule

// ==== verif/usr_station.sv ====
`timescale 1ns/1ps
module usr_station (
    input wire logic sys_clk,
    input wire logic clk_pin,
    input wire logic clk_drv_n,
    input wire logic dat_drv_n,
    input wire logic dat_val,
    output logic line
);
    logic async_q = 1'h1;
    logic [8:0] sync_q = 9'h000;
    logic [8:0] got_q = 9'h000;
    // bit time at divisor 1, high speed
    int bit_cyc = 32;
    assign line = clk_drv_n ? async_q : sync_q[0];
    // one frame, lsb first, stop level chosen by caller
    task automatic send(input logic [8:0] w, input int n, input logic stp);
        async_q <= 1'h0;
        repeat (bit_cyc) @(posedge sys_clk);
        for (int i = 0; i < n; i++) begin
            async_q <= w[i];
            repeat (bit_cyc) @(posedge sys_clk);
        end
        async_q <= stp;
        repeat (bit_cyc) @(posedge sys_clk);
        async_q <= 1'h1;
    endtask
    // slave takes bits on rise, offers next bit after fall
    always @(posedge clk_pin) if (!dat_drv_n) got_q <= {dat_val, got_q[8:1]};
    always @(negedge clk_pin) if (dat_drv_n) sync_q <= {1'h0, sync_q[8:1]};
endmodule

// ==== verif/usart_async_rx_sync_master_tb.sv ====
`timescale 1ns/1ps
module usart_async_rx_sync_master_tb;
    import usr_pkg::*;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic [2:0] reg_addr = 3'h0;
    usr_byte_t reg_wdata = 8'h00;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    usr_byte_t reg_rdata, got, b;
    usr_byte_t exp_q[$];
    logic d_o, d_oe_n, c_o, c_oe_n, rx_irq, tx_irq, st_line, pin;
    int err_count = 0;
    int checks_done = 0;
    int seed = 82;
    always #2 sys_clk = ~sys_clk;
    assign pin = d_oe_n ? st_line : d_o;
    usr_top dut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .serial_data_pin_i(pin), .serial_data_pin_o(d_o), .serial_data_pin_oe_n(d_oe_n),
        .shift_clock_pin_o(c_o), .shift_clock_pin_oe_n(c_oe_n), .receive_irq_req(rx_irq),
        .transmit_irq_req(tx_irq));
    usr_station st (.sys_clk, .clk_pin(c_o), .clk_drv_n(c_oe_n), .dat_drv_n(d_oe_n),
        .dat_val(d_o), .line(st_line));
    task automatic test_done();
        if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input usr_byte_t seen, input usr_byte_t want);
        checks_done++;
        if (seen !== want) begin
            err_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [2:0] a, input usr_byte_t d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
        @(posedge sys_clk);
    endtask
    // data sampled at the edge closing its slot
    task automatic rd(input logic [2:0] a, output usr_byte_t d);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask
    task automatic poll(input logic [2:0] a, input int k, input logic v);
        usr_byte_t d;
        for (int n = 0; n < 3000; n++) begin
            rd(a, d);
            if (d[k] === v) return;
        end
        check(8'h00, 8'hFF);
        test_done();
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'h0;
        @(posedge sys_clk);
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], got);
            check(got, (a == 2) ? 8'h02 : 8'h00);
        end
        wr(3'h3, 8'h01);
        wr(3'h2, 8'h04);
        wr(3'h6, 8'h20);
        wr(3'h0, 8'h90);
        for (int k = 0; k < 3; k++) begin
            b = usr_byte_t'($random(seed));
            exp_q.push_back(b);
            fork
                st.send({1'h0, b}, 8, 1'h1);
                poll(3'h5, 5, 1'h1);
            join
            check({7'h00, rx_irq}, 8'h01);
            rd(3'h1, got);
            check(got, exp_q.pop_front());
        end
        wr(3'h0, 8'hD8);
        fork
            st.send({1'h0, b}, 9, 1'h1);
            repeat (400) @(posedge sys_clk);
        join
        rd(3'h5, got);
        check(got, 8'h00);
        wr(3'h2, 8'h00);
        st.bit_cyc = 128;
        b = usr_byte_t'($random(seed));
        fork
            st.send({1'h1, b}, 9, 1'h0);
            poll(3'h5, 5, 1'h1);
        join
        rd(3'h0, got);
        check(got, 8'hDD);
        rd(3'h1, got);
        check(got, b);
        wr(3'h0, 8'h80);
        rd(3'h0, got);
        check(got & 8'h06, 8'h00);
        wr(3'h3, 8'h07);
        wr(3'h6, 8'h30);
        wr(3'h2, 8'hB0);
        rd(3'h5, got);
        check(got, 8'h10);
        check({7'h00, tx_irq}, 8'h01);
        wr(3'h5, 8'h00);
        rd(3'h5, got);
        check(got, 8'h10);
        b = usr_byte_t'($random(seed));
        wr(3'h4, b);
        poll(3'h2, 1, 1'h0);
        poll(3'h2, 1, 1'h1);
        check(st.got_q[8:1], b);
        b = usr_byte_t'($random(seed));
        st.sync_q = {1'h0, b};
        wr(3'h0, 8'hA0);
        poll(3'h5, 5, 1'h1);
        rd(3'h1, got);
        check(got, b);
        rd(3'h0, got);
        check(got & 8'hFE, 8'h80);
        test_done();
    end
endmodule
bind usr_top usr_top_properties chk (.sys_clk, .rst, .reg_wr, .reg_rd, .reg_rdata,
    .serial_data_pin_o, .serial_data_pin_oe_n, .shift_clock_pin_o, .shift_clock_pin_oe_n,
    .receive_irq_req, .transmit_irq_req);
